// ==== verilog/wwt_pkg.sv ====
// Constants, register map and types shared by the windowed watchdog files.
// Assumes byte addresses on a 5-bit register port with 32-bit data.
package wwt_pkg;
    // Register port geometry
    localparam int WWT_ADDR_W = 5;
    localparam int WWT_DATA_W = 32;
    localparam int WWT_CNT_W = 24;

    // Register byte offsets
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_MODE = 5'h00;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_TC = 5'h04;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_FEED = 5'h08;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_VALUE = 5'h0c;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_CLKSEL = 5'h10;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_WARN = 5'h14;
    localparam logic [WWT_ADDR_W-1:0] WWT_OFF_WINDOW = 5'h18;

    // Field positions in the watchdog_mode register, plus the clock select register bit
    localparam int WWT_BIT_EN = 0;
    localparam int WWT_BIT_RST = 1;
    localparam int WWT_BIT_TOF = 2;
    localparam int WWT_BIT_WINT = 3;
    localparam int WWT_BIT_PROT = 4;
    localparam int WWT_BIT_CLKSEL = 0;

    // Reset values and limits
    localparam logic [WWT_CNT_W-1:0] WWT_TC_MIN = 24'h00_00ff;
    localparam logic [WWT_CNT_W-1:0] WWT_TC_RESET = 24'h00_00ff;
    localparam logic [WWT_CNT_W-1:0] WWT_CNT_RESET = 24'h00_00ff;
    localparam logic [WWT_CNT_W-1:0] WWT_WIN_RESET = 24'hff_ffff;
    localparam logic [WWT_CNT_W-1:0] WWT_CNT_ZERO = 24'h00_0000;

    // Feed keys
    localparam logic [7:0] WWT_KEY_FIRST = 8'haa;
    localparam logic [7:0] WWT_KEY_SECOND = 8'h55;

    // Timing: prescaler terminal count and count-clock ticks to apply a write
    localparam logic [1:0] WWT_PRESC_LAST = 2'h3;
    localparam logic [1:0] WWT_SYNC_TICKS = 2'h3;

    // Feed sequence states
    typedef enum logic [1:0] {
        WWT_WAIT_FIRST = 2'b01,
        WWT_WAIT_SECOND = 2'b10
    } wwt_feed_st_t;
endpackage : wwt_pkg

// ==== verilog/wwt_tick_gen.sv ====
// Count clock selection and divide-by-four prescaler for the watchdog.
// Assumes both oscillator inputs are slow levels synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module wwt_tick_gen (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic i_sel, // 1 selects the watchdog oscillator
    input wire logic i_fast_osc, // Internal fast oscillator level
    input wire logic i_wdog_osc, // Watchdog oscillator level
    output logic o_count_tick, // One pulse per count clock edge
    output logic o_presc_tick // One pulse per four count clock edges
);
    import wwt_pkg::*;

    typedef struct packed {
        logic prev;
        logic [1:0] div;
        logic count_tick;
        logic presc_tick;
    } wwt_tick_st_t;

    wwt_tick_st_t q;
    wwt_tick_st_t n;
    logic lvl;

    // Source mux; switching sources may give one extra tick, harmless here
    assign lvl = i_sel ? i_wdog_osc : i_fast_osc;

    // Rising edge of the count clock, then divide by four
    always_comb begin
        n = q;
        n.prev = lvl;
        n.count_tick = lvl && !q.prev;
        n.presc_tick = 1'b0;
        if (lvl && !q.prev) begin
            n.div = q.div + 2'h1;
            n.presc_tick = (q.div == WWT_PRESC_LAST);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_count_tick = q.count_tick;
    assign o_presc_tick = q.presc_tick;

    // Prescale pulses stay four count edges apart
    presc_ratio_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q.presc_tick |-> q.count_tick && (q.div == 2'h0))
        else $error("prescale tick not on fourth count edge");
endmodule : wwt_tick_gen
`default_nettype wire

// ==== verilog/wwt_feed_seq.sv ====
// Two-write feed sequence checker for the watchdog.
// Assumes one write strobe per feed register access.
`timescale 1ns/1ps
`default_nettype none
module wwt_feed_seq (
    input wire logic i_clk, // System clock
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic i_wr, // Write to the feed register
    input wire logic [7:0] i_data, // Low byte of the write data
    output logic o_feed, // Pulse: complete feed seen
    output logic o_error // Pulse: feed sequence broken
);
    import wwt_pkg::*;

    typedef struct packed {
        wwt_feed_st_t st;
        logic feed;
        logic err;
    } wwt_feed_t;

    wwt_feed_t q;
    wwt_feed_t n;

    // First key arms, second key completes; anything else after arming breaks it
    always_comb begin
        n = q;
        n.feed = 1'b0;
        n.err = 1'b0;
        if (i_wr) begin
            unique case (q.st)
                WWT_WAIT_FIRST: begin
                    if (i_data == WWT_KEY_FIRST) begin
                        n.st = WWT_WAIT_SECOND;
                    end else if (i_data == WWT_KEY_SECOND) begin
                        n.err = 1'b1;
                    end
                end
                WWT_WAIT_SECOND: begin
                    n.st = WWT_WAIT_FIRST;
                    if (i_data == WWT_KEY_SECOND) begin
                        n.feed = 1'b1;
                    end else begin
                        n.err = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '{st: WWT_WAIT_FIRST, default: '0};
        end else begin
            q <= n;
        end
    end

    assign o_feed = q.feed;
    assign o_error = q.err;

    // A completed feed needs the first key just before
    feed_pair_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_wr && (i_data == WWT_KEY_SECOND) && (q.st == WWT_WAIT_SECOND) |=> o_feed && !o_error)
        else $error("second key did not complete feed");
endmodule : wwt_feed_seq
`default_nettype wire

// ==== verilog/wwt_top.sv ====
// Windowed watchdog timer: registers, 24-bit down counter, window and warning.
// Assumes a simple synchronous register port and a reset controller that
// acts on o_chip_reset; oscillators arrive as levels sampled by i_clk.
`timescale 1ns/1ps
`default_nettype none
module wwt_top (
    input wire logic i_clk, // System clock, 25 MHz
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic i_wr, // Register write strobe
    input wire logic i_rd, // Register read strobe
    input wire logic [wwt_pkg::WWT_ADDR_W-1:0] i_addr, // Register byte address
    input wire logic [wwt_pkg::WWT_DATA_W-1:0] i_wdata, // Write data
    input wire logic i_fast_osc, // Internal fast oscillator level
    input wire logic i_wdog_osc, // Watchdog oscillator level
    output logic [wwt_pkg::WWT_DATA_W-1:0] o_rdata, // Read data, one cycle after i_rd
    output logic o_chip_reset, // Pulse: watchdog chip reset request
    output logic o_timeout_flag, // Timeout flag level
    output logic o_warning_flag, // Warning flag level
    output logic o_running // Timer is counting
);
    import wwt_pkg::*;

    typedef struct packed {
        logic pend_en;
        logic pend_rst;
        logic pend_prot;
        logic en_act;
        logic rst_act;
        logic prot_act;
        logic tof;
        logic wint;
        logic clksel;
        logic [WWT_CNT_W-1:0] tc;
        logic [WWT_CNT_W-1:0] tc_act;
        logic [WWT_CNT_W-1:0] warn;
        logic [WWT_CNT_W-1:0] win;
        logic [WWT_CNT_W-1:0] cnt;
        logic [WWT_CNT_W-1:0] cnt_cap;
        logic [WWT_CNT_W-1:0] cnt_bus;
        logic [1:0] apply_cnt;
        logic [1:0] tc_cnt;
        logic [WWT_DATA_W-1:0] rdata;
        logic chip_rst;
    } wwt_st_t;

    localparam wwt_st_t WWT_ST_RST = '{
        tc: WWT_TC_RESET,
        tc_act: WWT_TC_RESET,
        win: WWT_WIN_RESET,
        cnt: WWT_CNT_RESET,
        cnt_cap: WWT_CNT_RESET,
        cnt_bus: WWT_CNT_RESET,
        default: '0
    };

    wwt_st_t q;
    wwt_st_t n;
    logic count_tick;
    logic presc_tick;
    logic feed_pulse;
    logic feed_err;
    logic wr_mode;
    logic wr_tc;
    logic wr_clksel;
    logic wr_warn;
    logic wr_win;
    logic wr_feed;
    logic tc_locked;
    logic event_c;
    logic [WWT_DATA_W-1:0] mode_rd;

    // Reload value with the floor applied; used on every reload path
    function automatic logic [WWT_CNT_W-1:0] wwt_clamp(input logic [WWT_CNT_W-1:0] v);
        wwt_clamp = (v < WWT_TC_MIN) ? WWT_TC_MIN : v;
    endfunction : wwt_clamp

    // Zero-extend a counter-width value onto the data bus
    function automatic logic [WWT_DATA_W-1:0] wwt_ext(input logic [WWT_CNT_W-1:0] v);
        wwt_ext = {{(WWT_DATA_W - WWT_CNT_W){1'b0}}, v};
    endfunction : wwt_ext

    wwt_tick_gen u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_sel(q.clksel),
        .i_fast_osc(i_fast_osc),
        .i_wdog_osc(i_wdog_osc),
        .o_count_tick(count_tick),
        .o_presc_tick(presc_tick)
    );

    wwt_feed_seq u_feed (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_wr(wr_feed),
        .i_data(i_wdata[7:0]),
        .o_feed(feed_pulse),
        .o_error(feed_err)
    );

    // Address decode of the write strobes
    assign wr_mode = i_wr && (i_addr == WWT_OFF_MODE);
    assign wr_tc = i_wr && (i_addr == WWT_OFF_TC);
    assign wr_feed = i_wr && (i_addr == WWT_OFF_FEED);
    assign wr_clksel = i_wr && (i_addr == WWT_OFF_CLKSEL);
    assign wr_warn = i_wr && (i_addr == WWT_OFF_WARN);
    assign wr_win = i_wr && (i_addr == WWT_OFF_WINDOW);

    // With protection applied, reload is locked until the counter is at or below both compare points
    assign tc_locked = q.prot_act && ((q.cnt > q.warn) || (q.cnt > q.win));

    // Mode readback: software sees what it wrote plus both flags
    always_comb begin
        mode_rd = '0;
        mode_rd[WWT_BIT_EN] = q.pend_en;
        mode_rd[WWT_BIT_RST] = q.pend_rst;
        mode_rd[WWT_BIT_TOF] = q.tof;
        mode_rd[WWT_BIT_WINT] = q.wint;
        mode_rd[WWT_BIT_PROT] = q.pend_prot;
    end

    // Next state: bus access first, then hardware events so a set beats a clear
    always_comb begin
        n = q;
        n.chip_rst = 1'b0;
        event_c = 1'b0;

        // Read mux; unmapped and write-only offsets read as zero
        if (i_rd) begin
            case (i_addr)
                WWT_OFF_MODE: n.rdata = mode_rd;
                WWT_OFF_TC: n.rdata = wwt_ext(q.tc);
                WWT_OFF_VALUE: n.rdata = wwt_ext(q.cnt_bus);
                WWT_OFF_CLKSEL: n.rdata = {{(WWT_DATA_W - 1){1'b0}}, q.clksel};
                WWT_OFF_WARN: n.rdata = wwt_ext(q.warn);
                WWT_OFF_WINDOW: n.rdata = wwt_ext(q.win);
                default: n.rdata = '0;
            endcase
        end

        // Mode write: sticky bits only ever set, flags only cleared by a 0
        if (wr_mode) begin
            n.pend_en = q.pend_en | i_wdata[WWT_BIT_EN];
            n.pend_rst = q.pend_rst | i_wdata[WWT_BIT_RST];
            n.pend_prot = q.pend_prot | i_wdata[WWT_BIT_PROT];
            if (!i_wdata[WWT_BIT_TOF]) begin
                n.tof = 1'b0;
            end
            if (!i_wdata[WWT_BIT_WINT]) begin
                n.wint = 1'b0;
            end
        end

        // Timeout constant: refused and flagged while protection holds
        if (wr_tc) begin
            if (tc_locked) begin
                event_c = 1'b1;
            end else begin
                n.tc = i_wdata[WWT_CNT_W-1:0];
                n.tc_cnt = WWT_SYNC_TICKS;
            end
        end
        if (wr_clksel) begin
            n.clksel = i_wdata[WWT_BIT_CLKSEL];
        end
        if (wr_warn) begin
            n.warn = i_wdata[WWT_CNT_W-1:0];
        end
        if (wr_win) begin
            n.win = i_wdata[WWT_CNT_W-1:0];
        end

        // Count clock edge: finish pending applies and capture the count
        if (count_tick) begin
            n.cnt_cap = q.cnt;
            if (q.tc_cnt != 2'h0) begin
                n.tc_cnt = q.tc_cnt - 2'h1;
                if (q.tc_cnt == 2'h1) begin
                    n.tc_act = q.tc;
                end
            end
            if (q.apply_cnt != 2'h0) begin
                n.apply_cnt = q.apply_cnt - 2'h1;
                if (q.apply_cnt == 2'h1) begin
                    n.en_act = q.pend_en;
                    n.rst_act = q.pend_rst;
                    n.prot_act = q.pend_prot;
                    n.cnt = wwt_clamp(q.tc_act);
                end
            end
        end

        // Completed feed: early feeds are events, good ones start the apply delay.
        // Placed after the tick so a feed landing on a tick restarts the delay
        if (feed_pulse) begin
            if (q.en_act && (q.cnt > q.win)) begin
                event_c = 1'b1;
            end else begin
                n.apply_cnt = WWT_SYNC_TICKS;
            end
        end
        if (feed_err && q.en_act) begin
            event_c = 1'b1;
        end

        // Prescaled tick: decrement, warn on match, event at zero
        if (presc_tick && q.en_act && (q.apply_cnt == 2'h0)) begin
            if (q.cnt == WWT_CNT_ZERO) begin
                event_c = 1'b1;
            end else begin
                n.cnt = q.cnt - 24'h00_0001;
            end
            if (q.cnt == q.warn) begin
                n.wint = 1'b1;
            end
        end

        // Second stage of the read path, read only by the bus mux
        n.cnt_bus = q.cnt_cap;

        // Watchdog event: set the flag; with reset enabled restore reset state except read data, the flag and the chip reset pulse
        if (event_c) begin
            n.tof = 1'b1;
            if (q.rst_act) begin
                n = WWT_ST_RST;
                n.rdata = q.rdata;
                n.tof = 1'b1;
                n.chip_rst = 1'b1;
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= WWT_ST_RST;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign o_rdata = q.rdata;
    assign o_chip_reset = q.chip_rst;
    assign o_timeout_flag = q.tof;
    assign o_warning_flag = q.wint;
    assign o_running = q.en_act;

    // Apply always loads at least the floor value
    reload_floor_a: assert property (@(posedge i_clk) disable iff (i_rst)
        count_tick && (q.apply_cnt == 2'h1) && !event_c |=> q.cnt >= WWT_TC_MIN)
        else $error("counter reloaded below floor");

    // Good feed arms the apply delay with the full tick count
    feed_apply_a: assert property (@(posedge i_clk) disable iff (i_rst)
        feed_pulse && !event_c |=> q.apply_cnt == WWT_SYNC_TICKS)
        else $error("feed did not start apply delay");

    // Zero reached while running sets the timeout flag
    underflow_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        presc_tick && q.en_act && (q.apply_cnt == 2'h0) && (q.cnt == WWT_CNT_ZERO) |=> q.tof)
        else $error("underflow did not set timeout flag");

    // Early feed is flagged
    early_feed_a: assert property (@(posedge i_clk) disable iff (i_rst)
        feed_pulse && q.en_act && (q.cnt > q.win) |=> q.tof && (q.apply_cnt == $past(q.apply_cnt)
            || q.chip_rst))
        else $error("early feed not treated as event");

    // Event with reset enabled pulses chip reset and stops the timer
    chip_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        event_c && q.rst_act |=> q.chip_rst && q.tof && !q.en_act ##1 !q.chip_rst)
        else $error("watchdog reset not issued");

    // Sticky enable survives any software write
    sticky_en_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q.pend_en && !(event_c && q.rst_act) |=> q.pend_en)
        else $error("enable bit cleared by software");

    // Warning match sets the warning flag
    warn_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
        presc_tick && q.en_act && (q.apply_cnt == 2'h0) && (q.cnt == q.warn) && !q.rst_act |=> q.wint)
        else $error("warning flag missed compare match");

    // Locked reload write leaves the constant and raises the flag
    protect_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_tc && tc_locked && !q.rst_act |=> q.tof && $stable(q.tc))
        else $error("protected reload value changed");

    // Broken sequence while running is an event
    feed_error_a: assert property (@(posedge i_clk) disable iff (i_rst)
        feed_err && q.en_act |=> q.tof)
        else $error("feed error not flagged");
endmodule : wwt_top
`default_nettype wire

// ==== tb/wwt_top_test.sv ====
// Self-checking bench for the windowed watchdog top level.
// Assumes wwt_pkg and the design modules are compiled first; the bench drives both oscillators.
`timescale 1ns/1ps
`default_nettype none
module wwt_top_test;
    import wwt_pkg::*;
    logic i_clk, i_rst, i_wr, i_rd, i_fast_osc, i_wdog_osc;
    logic [WWT_ADDR_W-1:0] i_addr;
    logic [WWT_DATA_W-1:0] i_wdata, o_rdata, v1, v2;
    logic o_chip_reset, o_timeout_flag, o_warning_flag, o_running;
    logic fast_stop, rst_seen;
    logic [1:0] fast_cnt;
    logic [2:0] slow_cnt;
    logic [23:0] rnd;
    int failures, n_tests;
    logic [WWT_ADDR_W-1:0] addrs [8] = '{WWT_OFF_MODE, WWT_OFF_TC, WWT_OFF_FEED, WWT_OFF_VALUE,
        WWT_OFF_CLKSEL, WWT_OFF_WARN, WWT_OFF_WINDOW, 5'h1c};
    logic [31:0] exps [8] = '{32'h0000_0000, 32'h0000_00ff, 32'h0000_0000, 32'h0000_00ff,
        32'h0000_0000, 32'h0000_0000, 32'h00ff_ffff, 32'h0000_0000};

    wwt_top dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_fast_osc(i_fast_osc), .i_wdog_osc(i_wdog_osc), .o_rdata(o_rdata), .o_chip_reset(o_chip_reset),
        .o_timeout_flag(o_timeout_flag), .o_warning_flag(o_warning_flag), .o_running(o_running)
    );

    // 25 MHz system clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Fast oscillator has a 4-clock period, watchdog oscillator 6 clocks, both well under i_clk/2
    always @(posedge i_clk) begin
        fast_cnt <= fast_cnt + 2'h1;
        slow_cnt <= (slow_cnt == 3'h5) ? 3'h0 : slow_cnt + 3'h1;
        i_fast_osc <= fast_stop ? 1'b0 : fast_cnt[1];
        i_wdog_osc <= (slow_cnt >= 3'h3);
        if (o_chip_reset === 1'b1) begin
            rst_seen <= 1'b1;
        end
    end

    // Counter load value: never below the minimum reload
    function automatic logic [31:0] exp_load(input logic [23:0] tc);
        return {8'h00, (tc < WWT_TC_MIN) ? WWT_TC_MIN : tc};
    endfunction : exp_load

    function automatic logic sig(input int w);
        case (w)
            0: return o_timeout_flag;
            1: return o_warning_flag;
            2: return o_running;
            default: return o_chip_reset;
        endcase
    endfunction : sig

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    // Bounded wait for an output to go high; running out ends the run
    task automatic wait_for(input int w, input int lim);
        int k;
        k = 0;
        while (sig(w) !== 1'b1 && k < lim) begin
            @(posedge i_clk);
            #1;
            k++;
        end
        cmp_bit(sig(w), 1'b1);
        if (sig(w) !== 1'b1) stop_test();
    endtask : wait_for

    // Strobe held for exactly one edge, released at the edge that takes it
    task automatic wr(input logic [WWT_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [WWT_ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic feed();
        wr(WWT_OFF_FEED, {24'h00_0000, WWT_KEY_FIRST});
        wr(WWT_OFF_FEED, {24'h00_0000, WWT_KEY_SECOND});
    endtask : feed

    // Writing 0 to the flag bits clears them; sticky bits ignore it
    task automatic clear_flags();
        wr(WWT_OFF_MODE, 32'h0000_0000);
        @(posedge i_clk);
        #1;
    endtask : clear_flags

    task automatic done(input string name);
        $display("test %s done", name);
    endtask : done

    initial begin
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_fast_osc = 1'b0;
        i_wdog_osc = 1'b0;
        fast_stop = 1'b0;
        rst_seen = 1'b0;
        fast_cnt = 2'h0;
        slow_cnt = 3'h0;
        failures = 0;
        n_tests = 0;
        rnd = 24'($urandom(32'h6b81b954));
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(addrs[i], v1);
            cmp_val(v1, exps[i]);
        end
        done("reset values");
        // Compare registers keep 24 bits, upper bits read 0
        rnd = 24'($urandom());
        wr(WWT_OFF_WARN, {8'hff, rnd});
        rd(WWT_OFF_WARN, v1);
        cmp_val(v1, {8'h00, rnd});
        wr(WWT_OFF_WINDOW, {8'hff, ~rnd});
        rd(WWT_OFF_WINDOW, v1);
        cmp_val(v1, {8'h00, ~rnd});
        wr(WWT_OFF_WINDOW, 32'h00ff_ffff);
        wr(WWT_OFF_TC, 32'h0000_0010);
        wr(WWT_OFF_VALUE, 32'h0000_1234);
        rd(WWT_OFF_VALUE, v1);
        cmp_val(v1, 32'h0000_00ff);
        wr(WWT_OFF_WARN, 32'h0000_00f0);
        wr(WWT_OFF_MODE, 32'h0000_0001);
        repeat (20) @(posedge i_clk);
        #1 cmp_bit(o_running, 1'b0);
        feed();
        wait_for(2, 60);
        rd(WWT_OFF_VALUE, v1);
        cmp_bit(v1 <= exp_load(24'h00_0010) && v1 >= 32'h0000_00f8, 1'b1);
        done("start");
        wr(WWT_OFF_MODE, 32'h0000_0000);
        repeat (2) @(posedge i_clk);
        #1 cmp_bit(o_running, 1'b1);
        rd(WWT_OFF_MODE, v1);
        cmp_bit(v1[WWT_BIT_EN], 1'b1);
        done("no stop");
        wait_for(1, 600);
        clear_flags();
        cmp_bit(o_warning_flag, 1'b0);
        done("warning");
        // Lone second key, then first key with a wrong follower
        wr(WWT_OFF_FEED, {24'h00_0000, WWT_KEY_SECOND});
        wait_for(0, 8);
        clear_flags();
        cmp_bit(o_timeout_flag, 1'b0);
        rnd = 24'($urandom());
        if (rnd[7:0] == WWT_KEY_SECOND) rnd[7:0] = 8'h5a;
        wr(WWT_OFF_FEED, {24'h00_0000, WWT_KEY_FIRST});
        wr(WWT_OFF_FEED, {24'h00_0000, rnd[7:0]});
        wait_for(0, 8);
        clear_flags();
        done("feed errors");
        wr(WWT_OFF_WINDOW, 32'h0000_0080);
        feed();
        wait_for(0, 8);
        wr(WWT_OFF_WINDOW, 32'h00ff_ffff);
        clear_flags();
        done("early feed");
        // Interrupt mode underflow sets the flag without a chip reset
        feed();
        wait_for(0, 6000);
        cmp_bit(rst_seen, 1'b0);
        feed();
        repeat (40) @(posedge i_clk);
        clear_flags();
        cmp_bit(o_timeout_flag, 1'b0);
        done("underflow");
        // Stopping the fast source proves the count follows the selection
        wr(WWT_OFF_CLKSEL, 32'h0000_0001);
        rd(WWT_OFF_CLKSEL, v1);
        cmp_val(v1, 32'h0000_0001);
        fast_stop <= 1'b1;
        repeat (30) @(posedge i_clk);
        rd(WWT_OFF_VALUE, v1);
        repeat (240) @(posedge i_clk);
        rd(WWT_OFF_VALUE, v2);
        cmp_bit((v1 - v2) >= 32'd8 && (v1 - v2) <= 32'd12, 1'b1);
        done("clock select");
        wr(WWT_OFF_MODE, 32'h0000_0011);
        feed();
        repeat (80) @(posedge i_clk);
        rnd = 24'($urandom()) | 24'h00_0100;
        wr(WWT_OFF_TC, {8'h00, rnd});
        wait_for(0, 8);
        rd(WWT_OFF_TC, v1);
        cmp_val(v1, 32'h0000_0010);
        clear_flags();
        done("protect");
        wr(WWT_OFF_MODE, 32'h0000_0003);
        feed();
        wait_for(3, 8000);
        @(posedge i_clk);
        #1 cmp_bit(o_timeout_flag, 1'b1);
        cmp_bit(o_running, 1'b0);
        cmp_bit(o_warning_flag, 1'b0);
        rd(WWT_OFF_MODE, v1);
        cmp_val(v1, 32'h0000_0004);
        rd(WWT_OFF_TC, v1);
        cmp_val(v1, 32'h0000_00ff);
        done("chip reset");
        stop_test();
    end
endmodule : wwt_top_test
`default_nettype wire
